// ---- rtl/rdc_regs_pkg.sv ----
// Shared constants and types of the converter register bank.
// Assumes one 20 MHz clock domain and an 8-bit host data port.
package rdc_regs_pkg;
   // Register offsets on the host data port.
   localparam logic [7:0] ANGLE_HIGH_BYTE_OFS = 8'h80;
   localparam logic [7:0] ANGLE_LOW_BYTE_OFS = 8'h81;
   localparam logic [7:0] SPEED_HIGH_BYTE_OFS = 8'h82;
   localparam logic [7:0] SPEED_LOW_BYTE_OFS = 8'h83;
   localparam logic [7:0] SIGNAL_FLOOR_LIMIT_OFS = 8'h88;
   localparam logic [7:0] AMPLITUDE_CEILING_LIMIT_OFS = 8'h89;
   localparam logic [7:0] AMPLITUDE_SPREAD_LIMIT_OFS = 8'h8a;
   localparam logic [7:0] TRACKER_MAX_PRESET_OFS = 8'h8b;
   localparam logic [7:0] TRACKER_MIN_PRESET_OFS = 8'h8c;
   localparam logic [7:0] TRACKING_ERROR_SET_LIMIT_OFS = 8'h8d;
   localparam logic [7:0] TRACKING_ERROR_CLEAR_LIMIT_OFS = 8'h8e;
   localparam logic [7:0] EXCITATION_RATE_WORD_OFS = 8'h91;
   localparam logic [7:0] OPERATING_SETTINGS_OFS = 8'h92;
   localparam logic [7:0] SOFTWARE_RESTART_OFS = 8'hf0;
   localparam logic [7:0] FAULT_FLAGS_OFS = 8'hff;
   // Threshold store: index of each 7-bit threshold in the store.
   localparam int THR_COUNT = 7;
   localparam logic [2:0] THR_FLOOR = 3'h0;
   localparam logic [2:0] THR_CEILING = 3'h1;
   localparam logic [2:0] THR_SPREAD = 3'h2;
   localparam logic [2:0] THR_MAX_PRESET = 3'h3;
   localparam logic [2:0] THR_MIN_PRESET = 3'h4;
   localparam logic [2:0] THR_SLIP_SET = 3'h5;
   localparam logic [2:0] THR_SLIP_CLEAR = 3'h6;
   // Voltage thresholds in millivolts, step of one code.
   localparam int THR_STEP_MV = 38;
   localparam int FLOOR_DEFAULT_MV = 2200;
   localparam int CEILING_DEFAULT_MV = 4100;
   localparam int SPREAD_DEFAULT_MV = 380;
   localparam int MIN_PRESET_DEFAULT_MV = 3990;
   localparam int MAX_PRESET_DEFAULT_MV = 2280;
   // Nearest code to a voltage.
   localparam int FLOOR_DEFAULT_I = (FLOOR_DEFAULT_MV + THR_STEP_MV / 2) / THR_STEP_MV;
   localparam int CEILING_DEFAULT_I = (CEILING_DEFAULT_MV + THR_STEP_MV / 2) / THR_STEP_MV;
   localparam int SPREAD_DEFAULT_I = (SPREAD_DEFAULT_MV + THR_STEP_MV / 2) / THR_STEP_MV;
   localparam int MIN_PRESET_DEFAULT_I = (MIN_PRESET_DEFAULT_MV + THR_STEP_MV / 2) / THR_STEP_MV;
   localparam int MAX_PRESET_DEFAULT_I = (MAX_PRESET_DEFAULT_MV + THR_STEP_MV / 2) / THR_STEP_MV;
   localparam logic [6:0] FLOOR_DEFAULT = FLOOR_DEFAULT_I[6:0];
   localparam logic [6:0] CEILING_DEFAULT = CEILING_DEFAULT_I[6:0];
   localparam logic [6:0] SPREAD_DEFAULT = SPREAD_DEFAULT_I[6:0];
   localparam logic [6:0] MIN_PRESET_DEFAULT = MIN_PRESET_DEFAULT_I[6:0];
   localparam logic [6:0] MAX_PRESET_DEFAULT = MAX_PRESET_DEFAULT_I[6:0];
   // Tracking thresholds in hundredths of a degree; step per resolution.
   localparam int SLIP_STEP_10_CD = 35;
   localparam int SLIP_STEP_12_CD = 14;
   localparam int SLIP_STEP_14_CD = 9;
   localparam int SLIP_CLEAR_10_CD = 250;
   localparam int SLIP_SET_10_CD = 1250;
   localparam int SLIP_CLEAR_12_CD = 100;
   localparam int SLIP_SET_12_CD = 500;
   localparam int SLIP_CLEAR_14_CD = 50;
   localparam int SLIP_SET_14_CD = 250;
   localparam int SLIP_SET_DEFAULT_I = (SLIP_SET_12_CD + SLIP_STEP_12_CD / 2) / SLIP_STEP_12_CD;
   localparam int SLIP_CLEAR_DEFAULT_I = (SLIP_CLEAR_12_CD + SLIP_STEP_12_CD / 2) / SLIP_STEP_12_CD;
   localparam logic [6:0] SLIP_SET_DEFAULT = SLIP_SET_DEFAULT_I[6:0];
   localparam logic [6:0] SLIP_CLEAR_DEFAULT = SLIP_CLEAR_DEFAULT_I[6:0];
   // Control register fields and power-up values.
   localparam logic [7:0] SETTINGS_RESET = 8'h7e;
   localparam logic [7:0] RATE_WORD_RESET = 8'h28;
   localparam int SET_HYST_BIT = 4;
   localparam int SET_RES_LSB = 0;
   // Fault register bit positions.
   localparam int FLT_FLOOR_BIT = 6;
   localparam int FLT_CEILING_BIT = 5;
   localparam int FLT_SPREAD_BIT = 4;
   localparam int FLT_SLIP_BIT = 3;
   // Resolution codes.
   typedef enum logic [1:0] {
      RES_10 = 2'b00,
      RES_12 = 2'b01,
      RES_14 = 2'b10,
      RES_16 = 2'b11
   } resolution_t;
   // Analog-side measurements entering the bank.
   typedef struct packed {
      logic [15:0] angle;
      logic [15:0] speed;
      logic [6:0] amplitude;
      logic [6:0] tracking_error;
      logic clipped;
      logic overspeed;
      logic phase_slip;
   } measure_t;
   // Host port word, one byte per access.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] data;
   } host_req_t;
endpackage

// ---- rtl/threshold_store.sv ----
// Seven-entry store of 8-bit threshold words with registered read data.
// Assumes writes and reads come from the bank's host decoder.
module threshold_store (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [2:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [2:0] rd_idx,
   output logic [7:0] rd_data,
   output logic [rdc_regs_pkg::THR_COUNT*7-1:0] values
);
   import rdc_regs_pkg::*;
   logic [7:0] mem_q [THR_COUNT];
   logic [7:0] rd_q;
   // Power-up code of each entry, top bit holds parity of the low seven.
   function automatic logic [7:0] preset(input int i);
      logic [6:0] v;
      v = 7'h00;
      unique case (i)
         0: v = FLOOR_DEFAULT;
         1: v = CEILING_DEFAULT;
         2: v = SPREAD_DEFAULT;
         3: v = MAX_PRESET_DEFAULT;
         4: v = MIN_PRESET_DEFAULT;
         5: v = SLIP_SET_DEFAULT;
         default: v = SLIP_CLEAR_DEFAULT;
      endcase
      return {^v, v};
   endfunction
   // One flop word per entry, loaded on a matching write.
   for (genvar g = 0; g < THR_COUNT; g++) begin : g_ent
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            mem_q[g] <= preset(g);
         end else if (wr_en && wr_idx == 3'(g)) begin
            mem_q[g] <= wr_data;
         end
      end
      assign values[g*7 +: 7] = mem_q[g][6:0];
   end
   // Read data leaves through a register.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_q <= 8'h00;
      end else begin
         rd_q <= (int'(rd_idx) < THR_COUNT) ? mem_q[rd_idx] : 8'h00;
      end
   end
   assign rd_data = rd_q;
endmodule

// ---- rtl/fault_monitor.sv ----
// Amplitude and tracking fault detection from programmed thresholds.
// Assumes amplitude and error samples are in threshold code units.
module fault_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic clear,
   input wire logic [6:0] amplitude,
   input wire logic [6:0] tracking_error,
   input wire logic [6:0] floor_lim,
   input wire logic [6:0] ceiling_lim,
   input wire logic [6:0] spread_lim,
   input wire logic [6:0] max_preset,
   input wire logic [6:0] min_preset,
   input wire logic [6:0] slip_set,
   input wire logic [6:0] slip_clear,
   output logic amp_low,
   output logic amp_high,
   output logic amp_spread,
   output logic slip
);
   logic [6:0] min_q;
   logic [6:0] max_q;
   logic slip_q;
   logic [6:0] spread;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         min_q <= 7'h7f;
         max_q <= 7'h00;
      end else if (clear) begin
         min_q <= min_preset;
         max_q <= max_preset;
      end else begin
         min_q <= (amplitude < min_q) ? amplitude : min_q;
         max_q <= (amplitude > max_q) ? amplitude : max_q;
      end
   end
   assign spread = (max_q > min_q) ? 7'(max_q - min_q) : 7'h00;
   assign amp_spread = spread > spread_lim;
   assign amp_low = amplitude < floor_lim;
   assign amp_high = amplitude > ceiling_lim;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         slip_q <= 1'b0;
      end else if (tracking_error > slip_set) begin
         slip_q <= 1'b1;
      end else if (tracking_error < slip_clear) begin
         slip_q <= 1'b0;
      end
   end
   assign slip = slip_q;
endmodule

// ---- rtl/rdc_register_bank.sv ----
// Register bank of a resolver-to-digital converter: results, thresholds, control and faults.
// Assumes a host writing and reading bytes on the data port, and analog-side measurements.
module rdc_register_bank (
   input wire logic clk,
   input wire logic nrst,
   input wire logic mode_select_lo,
   input wire logic mode_select_hi,
   input wire logic precision_sel_0,
   input wire logic precision_sel_1,
   input wire logic sample_strobe,
   input wire rdc_regs_pkg::host_req_t host_req,
   input wire rdc_regs_pkg::measure_t measure,
   output logic [7:0] host_rdata,
   output logic [15:0] result_word,
   output rdc_regs_pkg::resolution_t resolution,
   output logic hysteresis_on,
   output logic [7:0] excitation_rate,
   output logic [7:0] settings_word,
   output logic restart_pulse,
   output logic degradation_n,
   output logic slip_n
);
   import rdc_regs_pkg::*;

   logic strobe_q;
   logic [15:0] angle_q;
   logic [15:0] speed_q;
   logic [7:0] addr_q;
   logic [7:0] rate_q;
   logic [7:0] settings_q;
   logic [7:0] faults_q;
   logic [7:0] rdata_q;
   logic [7:0] low_hold_q;
   logic [7:0] store_rd;
   logic [THR_COUNT*7-1:0] thr;
   logic restart_q;
   logic clear_q;
   logic [7:0] thr_word;

   logic config_mode;
   logic strobe_fall;
   logic wr_addr;
   logic wr_data;
   logic rd_go;
   logic [15:0] res_mask;
   logic [15:0] angle_in;
   logic thr_hit;
   logic [2:0] thr_idx;
   logic [7:0] data_word;
   logic amp_low;
   logic amp_high;
   logic amp_spread;
   logic slip;
   logic [7:0] fault_now;
   logic [7:0] rd_mux;
   logic rd_is_thr;
   logic rd_is_thr_q;

   assign config_mode = mode_select_lo & mode_select_hi;

   assign resolution = config_mode ? resolution_t'({settings_q[SET_RES_LSB], settings_q[SET_RES_LSB + 1]})
      : resolution_t'({precision_sel_0, precision_sel_1});
   assign hysteresis_on = settings_q[SET_HYST_BIT];

   // Mask of the valid high-order position bits at each resolution.
   always_comb begin
      res_mask = 16'hffff;
      unique case (resolution)
         RES_10: res_mask = 16'hffc0;
         RES_12: res_mask = 16'hfff0;
         RES_14: res_mask = 16'hfffc;
         RES_16: res_mask = 16'hffff;
      endcase
   end

   assign angle_in = hysteresis_on ? (measure.angle & res_mask) : measure.angle;

   assign strobe_fall = strobe_q & ~sample_strobe;

   // Strobe history for edge detection.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= sample_strobe;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         angle_q <= 16'h0000;
         speed_q <= 16'h0000;
      end else if (strobe_fall) begin
         angle_q <= angle_in;
         speed_q <= measure.speed;
      end
   end

   // Normal-mode parallel output: position or velocity, chosen by mode_select_hi alone.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         result_word <= 16'h0000;
      end else begin
         result_word <= mode_select_hi ? speed_q : angle_q;
      end
   end

   assign wr_addr = host_req.wr & config_mode & host_req.data[7];
   assign wr_data = host_req.wr & config_mode & ~host_req.data[7];
   assign rd_go = host_req.rd & config_mode;

   assign data_word = {^host_req.data[6:0], host_req.data[6:0]};

   // Pointer register of the last address word written.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_q <= 8'h00;
      end else if (wr_addr) begin
         addr_q <= host_req.data;
      end
   end

   // Threshold index for the current pointer.
   assign thr_hit = (addr_q >= SIGNAL_FLOOR_LIMIT_OFS) && (addr_q <= TRACKING_ERROR_CLEAR_LIMIT_OFS);
   assign thr_idx = 3'(addr_q - SIGNAL_FLOOR_LIMIT_OFS);

   threshold_store u_store (
      .clk(clk),
      .nrst(nrst),
      .wr_en(wr_data & thr_hit),
      .wr_idx(thr_idx),
      .wr_data(data_word),
      .rd_idx(thr_idx),
      .rd_data(store_rd),
      .values(thr)
   );

   // Rate word and settings, both parity-carrying data words.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rate_q <= RATE_WORD_RESET;
         settings_q <= SETTINGS_RESET;
      end else if (wr_data && addr_q == EXCITATION_RATE_WORD_OFS) begin
         rate_q <= data_word;
      end else if (wr_data && addr_q == OPERATING_SETTINGS_OFS) begin
         settings_q <= data_word;
      end
   end
   assign excitation_rate = rate_q;
   assign settings_word = settings_q;

   // Restart pulse when the restart address itself is written.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         restart_q <= 1'b0;
      end else begin
         restart_q <= wr_addr && host_req.data == SOFTWARE_RESTART_OFS;
      end
   end
   assign restart_pulse = restart_q;

   fault_monitor u_mon (
      .clk(clk),
      .nrst(nrst),
      .clear(clear_q),
      .amplitude(measure.amplitude),
      .tracking_error(measure.tracking_error),
      .floor_lim(thr[THR_FLOOR*7 +: 7]),
      .ceiling_lim(thr[THR_CEILING*7 +: 7]),
      .spread_lim(thr[THR_SPREAD*7 +: 7]),
      .max_preset(thr[THR_MAX_PRESET*7 +: 7]),
      .min_preset(thr[THR_MIN_PRESET*7 +: 7]),
      .slip_set(thr[THR_SLIP_SET*7 +: 7]),
      .slip_clear(thr[THR_SLIP_CLEAR*7 +: 7]),
      .amp_low(amp_low),
      .amp_high(amp_high),
      .amp_spread(amp_spread),
      .slip(slip)
   );

   // Live fault conditions in register bit order.
   assign fault_now = {measure.clipped, amp_low, amp_high, amp_spread, slip,
      measure.overspeed, measure.phase_slip, 1'b0};

   // fault clear detect
   // An address word written while the pointer already holds the fault register, or a restart, counts as the clear.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clear_q <= 1'b0;
      end else begin
         clear_q <= (wr_addr && addr_q == FAULT_FLAGS_OFS) || restart_q;
      end
   end

   // Sticky faults; a new fault in the clear cycle wins over the clear.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         faults_q <= 8'h00;
      end else if (clear_q) begin
         faults_q <= fault_now;
      end else begin
         faults_q <= faults_q | fault_now;
      end
   end
   assign degradation_n = ~|{faults_q[7:4], faults_q[2:1]};
   assign slip_n = ~faults_q[FLT_SLIP_BIT];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_hold_q <= 8'h00;
      end else if (rd_go && addr_q == ANGLE_HIGH_BYTE_OFS) begin
         low_hold_q <= angle_q[7:0];
      end else if (rd_go && addr_q == SPEED_HIGH_BYTE_OFS) begin
         low_hold_q <= speed_q[7:0];
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      unique case (addr_q)
         ANGLE_HIGH_BYTE_OFS: rd_mux = angle_q[15:8];
         ANGLE_LOW_BYTE_OFS: rd_mux = low_hold_q;
         SPEED_HIGH_BYTE_OFS: rd_mux = speed_q[15:8];
         SPEED_LOW_BYTE_OFS: rd_mux = low_hold_q;
         EXCITATION_RATE_WORD_OFS: rd_mux = {^rate_q, rate_q[6:0]};
         OPERATING_SETTINGS_OFS: rd_mux = {^settings_q, settings_q[6:0]};
         FAULT_FLAGS_OFS: rd_mux = faults_q;
         default: rd_mux = 8'h00;
      endcase
   end

   // Read data register; the threshold path comes from the registered store read in the same cycle as other reads.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
         rd_is_thr_q <= 1'b0;
      end else begin
         rdata_q <= rd_go ? rd_mux : (rd_is_thr_q ? thr_word : rdata_q);
         rd_is_thr_q <= rd_go & rd_is_thr;
      end
   end
   assign rd_is_thr = thr_hit;
   assign thr_word = {^store_rd, store_rd[6:0]};

   assign host_rdata = rd_is_thr_q ? thr_word : rdata_q;
endmodule

// ---- dv/rdc_register_bank_asserts.sv ----
// Concurrent checks on the port behaviour of the converter register bank.
// Assumes binding to rdc_register_bank, one clock and an active low async reset.
module rdc_register_bank_asserts (
   input wire logic clk,
   input wire logic nrst,
   input wire logic mode_select_lo,
   input wire logic mode_select_hi,
   input wire logic precision_sel_0,
   input wire logic precision_sel_1,
   input wire logic sample_strobe,
   input wire rdc_regs_pkg::host_req_t host_req,
   input wire rdc_regs_pkg::measure_t measure,
   input wire logic [7:0] host_rdata,
   input wire logic [15:0] result_word,
   input wire rdc_regs_pkg::resolution_t resolution,
   input wire logic hysteresis_on,
   input wire logic [7:0] excitation_rate,
   input wire logic [7:0] settings_word,
   input wire logic restart_pulse,
   input wire logic degradation_n,
   input wire logic slip_n
);
   import rdc_regs_pkg::*;
   logic cfg, wr_ok, rd_ok, rst_req, clr_req, set_wr, rate_wr;
   logic [6:0] wd;
   logic [1:0] res_exp;
   logic [7:0] ptr_q;
   // Decode of accepted host words, mirrored from the port contract.
   assign cfg = mode_select_lo && mode_select_hi;
   assign wr_ok = cfg && host_req.wr;
   assign rd_ok = cfg && host_req.rd;
   assign wd = host_req.data[6:0];
   assign rst_req = wr_ok && host_req.data == SOFTWARE_RESTART_OFS;
   assign clr_req = rst_req || (wr_ok && host_req.data[7] && ptr_q == FAULT_FLAGS_OFS);
   assign set_wr = wr_ok && !host_req.data[7] && ptr_q == OPERATING_SETTINGS_OFS;
   assign rate_wr = wr_ok && !host_req.data[7] && ptr_q == EXCITATION_RATE_WORD_OFS;
   assign res_exp = cfg ? {settings_word[0], settings_word[1]} : {precision_sel_0, precision_sel_1};
   // Tracks the address pointer so data words can be attributed.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ptr_q <= 8'h00;
      end else if (wr_ok && host_req.data[7]) begin
         ptr_q <= host_req.data;
      end
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_write_gated: assert property (!wr_ok |=> $stable(settings_word) && $stable(excitation_rate))
      else $error("Register changed without an accepted write.");
   a_settings_parity: assert property (set_wr |=> settings_word == {^$past(wd), $past(wd)})
      else $error("Settings word not stored with parity.");
   a_rate_parity: assert property (rate_wr |=> excitation_rate == {^$past(wd), $past(wd)})
      else $error("Rate word not stored with parity.");
   a_restart_follows: assert property (rst_req |=> restart_pulse)
      else $error("Restart pulse missing after restart address.");
   a_res_select: assert property (resolution == res_exp)
      else $error("Resolution not taken from the right source.");
   a_slip_sticky: assert property ($rose(slip_n) |-> $past(clr_req, 2) || $past(clr_req, 3))
      else $error("Slip fault released without a fault clear.");
   a_degrade_sticky: assert property ($rose(degradation_n) |-> $past(clr_req, 2) || $past(clr_req, 3))
      else $error("Degradation fault released without a fault clear.");
   a_result_hold: assert property (($stable(sample_strobe) && $stable(mode_select_hi)) [*5] |-> $stable(result_word))
      else $error("Result word changed between strobes.");
   a_rdata_hold: assert property ($changed(host_rdata) |-> $past(rd_ok) || $past(rd_ok, 2))
      else $error("Read data changed without an accepted read.");
   c_restart: cover property (rst_req ##1 restart_pulse);
   c_slip: cover property ($fell(slip_n));
   c_strobe: cover property ($fell(sample_strobe));
endmodule

bind rdc_register_bank rdc_register_bank_asserts u_rdc_register_bank_asserts (
   .clk(clk), .nrst(nrst), .mode_select_lo(mode_select_lo), .mode_select_hi(mode_select_hi),
   .precision_sel_0(precision_sel_0), .precision_sel_1(precision_sel_1), .sample_strobe(sample_strobe),
   .host_req(host_req), .measure(measure), .host_rdata(host_rdata), .result_word(result_word),
   .resolution(resolution), .hysteresis_on(hysteresis_on), .excitation_rate(excitation_rate),
   .settings_word(settings_word), .restart_pulse(restart_pulse), .degradation_n(degradation_n), .slip_n(slip_n));

// ---- dv/host_port_model.sv ----
// Host controller model driving mode selects and byte words on the data port.
// Assumes the bench calls its tasks; words change 2 ns after a rising edge.
module host_port_model (
   input wire logic clk,
   output logic mode_select_lo,
   output logic mode_select_hi,
   output rdc_regs_pkg::host_req_t host_req,
   input wire logic [7:0] host_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import rdc_regs_pkg::*;
   initial begin
      host_req = '0;
      mode_select_lo = 1'b1;
      mode_select_hi = 1'b1;
   end
   task automatic put(input logic w, input logic r, input logic [7:0] b);
      @(posedge clk);
      #2;
      host_req = '{wr: w, rd: r, data: b};
   endtask
   // Idle data shows the inverse of the last byte so stale values never match.
   task automatic idle();
      put(1'b0, 1'b0, ~host_req.data);
   endtask
   task automatic set_mode(input logic lo, input logic hi);
      @(posedge clk);
      #2;
      mode_select_lo = lo;
      mode_select_hi = hi;
   endtask
   // Address word top set, data word top clear.
   task automatic write_reg(input logic [7:0] ofs, input logic [6:0] d);
      put(1'b1, 1'b0, ofs | 8'h80);
      put(1'b1, 1'b0, {1'b0, d});
      idle();
   endtask
   task automatic read_reg(input logic [7:0] ofs, output logic [7:0] v);
      put(1'b1, 1'b0, ofs | 8'h80);
      put(1'b0, 1'b1, 8'h00);
      idle();
      @(posedge clk);
      #2;
      v = host_rdata;
   endtask
   task automatic clear_faults();
      put(1'b1, 1'b0, FAULT_FLAGS_OFS);
      put(1'b1, 1'b0, FAULT_FLAGS_OFS);
      idle();
   endtask
   task automatic soft_restart();
      put(1'b1, 1'b0, SOFTWARE_RESTART_OFS);
      idle();
   endtask
endmodule

// ---- dv/tb_resolver_converter_register_bank.sv ----
// Self-checking bench of the converter register bank with a host model.
// Assumes a 50 ns clock and results loaded two edges after a strobe fall.
module tb_resolver_converter_register_bank;
   timeunit 1ns;
   timeprecision 1ps;
   import rdc_regs_pkg::*;
   logic clk, nrst, mode_select_lo, mode_select_hi, precision_sel_0, precision_sel_1, sample_strobe;
   host_req_t host_req;
   measure_t measure;
   resolution_t resolution;
   logic [7:0] host_rdata, excitation_rate, settings_word, q, hi;
   logic [15:0] result_word, exp_a, exp_s;
   logic hysteresis_on, restart_pulse, degradation_n, slip_n;
   logic [6:0] d;
   int n_mismatch, n_tests, seed;
   logic [7:0] ofs [7] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e};
   int mv [7] = '{2200, 4100, 380, 2280, 3990, 500, 100};
   int step [7] = '{38, 38, 38, 38, 38, 14, 14};
   // Presets sit one step either side of the amplitude of 80.
   logic [6:0] lim [5] = '{7'd58, 7'd108, 7'd10, 7'd79, 7'd81};
   rdc_register_bank u_rdc_register_bank (
      .clk(clk), .nrst(nrst), .mode_select_lo(mode_select_lo), .mode_select_hi(mode_select_hi),
      .precision_sel_0(precision_sel_0), .precision_sel_1(precision_sel_1), .sample_strobe(sample_strobe),
      .host_req(host_req), .measure(measure), .host_rdata(host_rdata), .result_word(result_word),
      .resolution(resolution), .hysteresis_on(hysteresis_on), .excitation_rate(excitation_rate),
      .settings_word(settings_word), .restart_pulse(restart_pulse), .degradation_n(degradation_n), .slip_n(slip_n));
   host_port_model u_host_port_model (.clk(clk), .mode_select_lo(mode_select_lo), .mode_select_hi(mode_select_hi),
      .host_req(host_req), .host_rdata(host_rdata));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [6:0] v);
      u_host_port_model.write_reg(a, v);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      u_host_port_model.read_reg(a, v);
   endtask
   task automatic settle();
      repeat (4) @(posedge clk);
      #2;
   endtask
   // Strobe falls for two edges, then the result load has time to land.
   task automatic strobe();
      @(posedge clk);
      #2;
      sample_strobe = 1'b0;
      repeat (2) @(posedge clk);
      #2;
      sample_strobe = 1'b1;
      settle();
   endtask
   function automatic logic [6:0] near(input int v, input int s);
      return 7'((v + s / 2) / s);
   endfunction
   function automatic logic [15:0] pos_exp(input logic [15:0] a, input logic [1:0] r, input logic hy);
      logic [15:0] m;
      m = 16'hffff << (2 * (3 - int'(r)));
      return hy ? (a & m) : a;
   endfunction
   // Free running clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Watchdog cuts a hang short after 20000 cycles.
   initial begin
      #1000000;
      n_mismatch++;
      give_verdict();
   end
   // Main sequence.
   initial begin
      nrst = 1'b0;
      sample_strobe = 1'b1;
      precision_sel_0 = 1'b0;
      precision_sel_1 = 1'b1;
      measure = '0;
      n_mismatch = 0;
      n_tests = 0;
      seed = $urandom(32'h2a7cbc6f);
      repeat (6) @(posedge clk);
      #2;
      nrst = 1'b1;
      check("settings reset", settings_word, 16'h7e);
      check("rate reset", excitation_rate, 16'h28);
      check("res reset", resolution, RES_12);
      for (int i = 0; i < 7; i++) begin
         rd(ofs[i], q);
         check("default limit", q, {1'b0, near(mv[i], step[i])});
      end
      for (int i = 0; i < 8; i++) begin
         d = 7'($urandom);
         wr(i < 7 ? ofs[i] : EXCITATION_RATE_WORD_OFS, d);
         rd(i < 7 ? ofs[i] : EXCITATION_RATE_WORD_OFS, q);
         check("readback", q, {1'b0, d});
      end
      check("rate word", excitation_rate, {^d, d});
      for (int m = 0; m < 3; m++) begin
         u_host_port_model.set_mode(m[1], m[0]);
         wr(EXCITATION_RATE_WORD_OFS, ~d);
         rd(EXCITATION_RATE_WORD_OFS, q);
         check("refused read", q, {1'b0, d});
      end
      u_host_port_model.set_mode(1'b1, 1'b1);
      check("refused write", excitation_rate, {^d, d});
      for (int k = 0; k < 8; k++) begin
         wr(OPERATING_SETTINGS_OFS, {2'b11, k[2], 2'b11, k[0], k[1]});
         check("cfg res", resolution, k[1:0]);
         check("hysteresis", hysteresis_on, k[2]);
         measure.angle = 16'($urandom);
         measure.speed = (k == 0) ? 16'h7fff : (k == 1) ? 16'h8000 : 16'($urandom);
         exp_a = pos_exp(measure.angle, k[1:0], k[2]);
         exp_s = ~measure.speed;
         strobe();
         measure.angle = ~measure.angle;
         measure.speed = exp_s;
         wr(ANGLE_HIGH_BYTE_OFS, 7'h55);
         rd(ANGLE_HIGH_BYTE_OFS, hi);
         strobe();
         rd(ANGLE_LOW_BYTE_OFS, q);
         check("angle", {hi, q}, exp_a);
         rd(SPEED_HIGH_BYTE_OFS, hi);
         rd(SPEED_LOW_BYTE_OFS, q);
         check("speed", {hi, q}, exp_s);
      end
      for (int p = 0; p < 4; p++) begin
         precision_sel_0 = p[1];
         precision_sel_1 = p[0];
         u_host_port_model.set_mode(1'b0, p[0]);
         settle();
         check("pin res", resolution, p[1:0]);
         check("result word", result_word, p[0] ? measure.speed : measure.angle);
      end
      u_host_port_model.set_mode(1'b1, 1'b1);
      wr(TRACKING_ERROR_SET_LIMIT_OFS, 7'd20);
      wr(TRACKING_ERROR_CLEAR_LIMIT_OFS, 7'd10);
      for (int e = 0; e < 2; e++) begin
         measure.tracking_error = e ? 7'd15 : 7'd30;
         settle();
         u_host_port_model.clear_faults();
         settle();
         check("slip held", slip_n, 1'b0);
      end
      measure.tracking_error = 7'd5;
      settle();
      u_host_port_model.soft_restart();
      settle();
      check("slip released", slip_n, 1'b1);
      measure.amplitude = 7'd80;
      for (int i = 0; i < 5; i++) begin
         wr(ofs[i], lim[i]);
      end
      u_host_port_model.clear_faults();
      settle();
      u_host_port_model.clear_faults();
      settle();
      check("no spread", degradation_n, 1'b1);
      wr(TRACKER_MAX_PRESET_OFS, 7'd100);
      u_host_port_model.clear_faults();
      settle();
      check("spread pin", degradation_n, 1'b0);
      rd(FAULT_FLAGS_OFS, q);
      check("spread flag", q[FLT_SPREAD_BIT], 1'b1);
      for (int i = 0; i < 2; i++) begin
         measure.amplitude = i ? 7'd120 : 7'd40;
         settle();
         rd(FAULT_FLAGS_OFS, q);
         check("level flag", q[i ? FLT_CEILING_BIT : FLT_FLOOR_BIT], 1'b1);
      end
      give_verdict();
   end
endmodule
